/* File: logic/pnpc_pkg.sv */
// package: offsets, field positions and reset values of the partner page and port configuration registers
package pnpc_pkg;
  localparam logic [4:0] PNPC_ADDR_PARTNER_PAGE = 5'h08;
  localparam logic [4:0] PNPC_ADDR_PORT_CONFIG = 5'h10;
  localparam logic [4:0] PNPC_ADDR_PAGE_STATUS = 5'h11;
  localparam int PNPC_BIT_MORE_PAGES = 15;
  localparam int PNPC_BIT_ACK = 14;
  localparam int PNPC_BIT_MSG_PAGE = 13;
  localparam int PNPC_BIT_SECOND_ACKNOWLEDGE = 12;
  localparam int PNPC_BIT_TOGGLE = 11;
  localparam int PNPC_BIT_FORCE_LINK = 14;
  localparam int PNPC_BIT_TX_DISABLE = 13;
  localparam int PNPC_BIT_BYP_SCRAMBLE = 12;
  localparam int PNPC_BIT_BYP_4B5B = 11;
  localparam int PNPC_BIT_JABBER_DIS = 10;
  localparam int PNPC_BIT_HEARTBEAT = 9;
  localparam int PNPC_BIT_LOOPBACK_DIS = 8;
  localparam int PNPC_BIT_CRS_EXTEND = 7;
  localparam int PNPC_BIT_PREAMBLE = 5;
  localparam int PNPC_BIT_SERIAL10 = 3;
  localparam int PNPC_BIT_FAR_FAULT = 2;
  localparam int PNPC_BIT_ALT_NP = 1;
  localparam int PNPC_BIT_FIBER = 0;
  localparam logic [15:0] PNPC_PAGE_RESET = 16'h0000;
  // bit 7 and far-end fault set; fiber bit comes from the strap
  localparam logic [15:0] PNPC_CONFIG_RESET = 16'h0084;
  // bits 15, 6 and 4 are reserved and hold no state
  localparam logic [15:0] PNPC_CONFIG_WMASK = 16'h7faf;
  // strap counter value at which the second synchroniser flop already holds the pin level
  localparam logic [1:0] PNPC_STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic force_link;
    logic tx_disable;
    logic bypass_scramble;
    logic bypass_4b5b;
    logic jabber_disable;
    logic heartbeat_test;
    logic loopback_disable;
    logic crs_extend;
    logic preamble_pass;
    logic serial_10m;
    logic far_fault_enable;
    logic alt_next_page;
    logic fiber_mode;
  } pnpc_ctrl_t;
endpackage : pnpc_pkg

/* File: logic/pnpc_regs.sv */
// partner next-page image and port configuration registers with plain register port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bit 8.15 shows partner has more next pages; resets zero.
// - bit 8.14 shows partner acknowledged our code word.
// - bit 8.12 shows partner second acknowledge: can comply with message.
// - bit 8.11 shows partner toggle flag.
// - bits 8.10:0 hold partner message or unformatted code; reset zero.
// - bit 16.14 forces link pass; resets zero.
// - bit 16.13 disables twisted-pair transmitter; resets zero.
// - bit 16.12 bypasses scrambler and descrambler at 100 Mbit.
// - bit 16.11 bypasses 4B/5B coding at 100 Mbit.
// - bit 16.9 enables heartbeat test at 10 Mbit; resets zero.
// - bit 16.8 suppresses 10 Mbit half-duplex loopback.
// - bit 16.7 extends carrier sense to receive-valid end; resets one.
// - bit 16.5 selects receive-valid at carrier sense with preamble.
// - bit 16.3 selects serial 10 Mbit receive data on line zero.
// - bit 16.1 enables alternate next-page behaviour; resets zero.
// - bit 16.0 selects fiber mode, else twisted pair.
// - bit 16.0 loads from media-select pin at hardware reset.
// - a new partner next page loads register 8 and flags reception.
module pnpc_regs
  import pnpc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic media_select_pin,
  input wire logic page_rx_strobe,
  input wire logic [15:0] page_rx_word,
  output pnpc_ctrl_t ctrl,
  output logic page_received
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic strap_taken_reg;
  logic [15:0] page_reg;
  logic [15:0] config_reg;
  logic page_flag_reg;
  logic [15:0] rdata_next;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // the strap is an outside pin, so it crosses two flops before use
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= media_select_pin;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // strap is caught three edges after release; one edge earlier the second flop still holds its reset zero
  logic [1:0] strap_wait_reg;
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      strap_wait_reg <= 2'h0;
      strap_taken_reg <= 1'b0;
    end else begin
      if (strap_wait_reg != PNPC_STRAP_SETTLE) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
      if (strap_wait_reg == PNPC_STRAP_SETTLE) begin
        strap_taken_reg <= 1'b1;
      end
    end
  end

  // partner page image: only the page engine writes it, reads never touch it
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      page_reg <= PNPC_PAGE_RESET;
    end else if (page_rx_strobe) begin
      page_reg <= page_rx_word;
    end
  end

  // reception flag clears on read of the status word; a new page in that cycle wins
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      page_flag_reg <= 1'b0;
    end else if (page_rx_strobe) begin
      page_flag_reg <= 1'b1;
    end else if (reg_read && reg_addr == PNPC_ADDR_PAGE_STATUS) begin
      page_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      config_reg <= PNPC_CONFIG_RESET;
    end else begin
      if (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG) begin
        config_reg <= reg_wdata & PNPC_CONFIG_WMASK;
      end else if (strap_wait_reg == PNPC_STRAP_SETTLE && !strap_taken_reg) begin
        config_reg[PNPC_BIT_FIBER] <= strap_sync_reg;
      end
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    if (reg_addr == PNPC_ADDR_PARTNER_PAGE) begin
      rdata_next = page_reg;
    end else if (reg_addr == PNPC_ADDR_PORT_CONFIG) begin
      rdata_next = config_reg & PNPC_CONFIG_WMASK;
    end else if (reg_addr == PNPC_ADDR_PAGE_STATUS) begin
      rdata_next = {15'h0000, page_flag_reg};
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // control outputs are flopped copies so they stand straight on flip-flops
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl <= '0;
      page_received <= 1'b0;
    end else begin
      ctrl.force_link <= config_reg[PNPC_BIT_FORCE_LINK];
      ctrl.tx_disable <= config_reg[PNPC_BIT_TX_DISABLE];
      ctrl.bypass_scramble <= config_reg[PNPC_BIT_BYP_SCRAMBLE];
      ctrl.bypass_4b5b <= config_reg[PNPC_BIT_BYP_4B5B];
      ctrl.jabber_disable <= config_reg[PNPC_BIT_JABBER_DIS];
      ctrl.heartbeat_test <= config_reg[PNPC_BIT_HEARTBEAT];
      ctrl.loopback_disable <= config_reg[PNPC_BIT_LOOPBACK_DIS];
      ctrl.crs_extend <= config_reg[PNPC_BIT_CRS_EXTEND];
      ctrl.preamble_pass <= config_reg[PNPC_BIT_PREAMBLE];
      ctrl.serial_10m <= config_reg[PNPC_BIT_SERIAL10];
      ctrl.far_fault_enable <= config_reg[PNPC_BIT_FAR_FAULT];
      ctrl.alt_next_page <= config_reg[PNPC_BIT_ALT_NP];
      ctrl.fiber_mode <= config_reg[PNPC_BIT_FIBER];
      page_received <= page_flag_reg;
    end
  end

  property p_page_load;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg == $past(page_rx_word);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page word not loaded");

  property p_page_hold;
    @(posedge clock) disable iff (!rst_sync_reg)
    (!page_rx_strobe && reg_read) |=> $stable(page_reg);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page word changed by read");

  property p_page_read;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_read && reg_addr == PNPC_ADDR_PARTNER_PAGE) |=> reg_rdata == $past(page_reg);
  endproperty
  a_page_read: assert property (p_page_read) else $error("page read data wrong");

  property p_force_link;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.force_link == $past(reg_wdata[PNPC_BIT_FORCE_LINK], 2);
  endproperty
  a_force_link: assert property (p_force_link) else $error("force link not applied");

  property p_tx_disable;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.tx_disable == $past(reg_wdata[PNPC_BIT_TX_DISABLE], 2);
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("transmit disable not applied");

  property p_reserved_zero;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_read && reg_addr == PNPC_ADDR_PORT_CONFIG) |=> (reg_rdata & ~PNPC_CONFIG_WMASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_page_flag;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> ##1 page_received;
  endproperty
  a_page_flag: assert property (p_page_flag) else $error("page reception not flagged");

  property p_strap;
    @(posedge clock) disable iff (!rst_sync_reg)
    (strap_wait_reg == PNPC_STRAP_SETTLE && !strap_taken_reg && !(reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG))
      |=> config_reg[PNPC_BIT_FIBER] == $past(strap_sync_reg);
  endproperty
  a_strap: assert property (p_strap) else $error("fiber bit not loaded from strap");

  property p_fiber_out;
    @(posedge clock) disable iff (!rst_sync_reg)
    ##1 ctrl.fiber_mode == $past(config_reg[PNPC_BIT_FIBER]);
  endproperty
  a_fiber_out: assert property (p_fiber_out) else $error("fiber mode output wrong");

  property p_bypass_scramble;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.bypass_scramble == $past(reg_wdata[PNPC_BIT_BYP_SCRAMBLE], 2);
  endproperty
  a_bypass_scramble: assert property (p_bypass_scramble) else $error("scrambler bypass not applied");

  property p_bypass_4b5b;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.bypass_4b5b == $past(reg_wdata[PNPC_BIT_BYP_4B5B], 2);
  endproperty
  a_bypass_4b5b: assert property (p_bypass_4b5b) else $error("coder bypass not applied");

  property p_jabber;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.jabber_disable == $past(reg_wdata[PNPC_BIT_JABBER_DIS], 2);
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber disable not applied");

  property p_heartbeat;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.heartbeat_test == $past(reg_wdata[PNPC_BIT_HEARTBEAT], 2);
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("heartbeat enable not applied");

  property p_loopback;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.loopback_disable == $past(reg_wdata[PNPC_BIT_LOOPBACK_DIS], 2);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback disable not applied");

  property p_crs_extend;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.crs_extend == $past(reg_wdata[PNPC_BIT_CRS_EXTEND], 2);
  endproperty
  a_crs_extend: assert property (p_crs_extend) else $error("carrier extend not applied");

  property p_preamble;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.preamble_pass == $past(reg_wdata[PNPC_BIT_PREAMBLE], 2);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble pass not applied");

  property p_serial;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.serial_10m == $past(reg_wdata[PNPC_BIT_SERIAL10], 2);
  endproperty
  a_serial: assert property (p_serial) else $error("serial mode not applied");

  property p_far_fault;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.far_fault_enable == $past(reg_wdata[PNPC_BIT_FAR_FAULT], 2);
  endproperty
  a_far_fault: assert property (p_far_fault) else $error("far fault enable not applied");

  property p_alt_np;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.alt_next_page == $past(reg_wdata[PNPC_BIT_ALT_NP], 2);
  endproperty
  a_alt_np: assert property (p_alt_np) else $error("alternate next page not applied");

  property p_fiber_write;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG)
      |=> ##1 ctrl.fiber_mode == $past(reg_wdata[PNPC_BIT_FIBER], 2);
  endproperty
  a_fiber_write: assert property (p_fiber_write) else $error("fiber select not applied");

  property p_more_pages;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg[PNPC_BIT_MORE_PAGES] == $past(page_rx_word[PNPC_BIT_MORE_PAGES]);
  endproperty
  a_more_pages: assert property (p_more_pages) else $error("more pages flag not loaded");

  property p_ack;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg[PNPC_BIT_ACK] == $past(page_rx_word[PNPC_BIT_ACK]);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge flag not loaded");

  property p_second_acknowledge;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg[PNPC_BIT_SECOND_ACKNOWLEDGE] == $past(page_rx_word[PNPC_BIT_SECOND_ACKNOWLEDGE]);
  endproperty
  a_second_acknowledge: assert property (p_second_acknowledge) else $error("second acknowledge not loaded");

  property p_toggle;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg[PNPC_BIT_TOGGLE] == $past(page_rx_word[PNPC_BIT_TOGGLE]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle flag not loaded");

  property p_code_field;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_reg[PNPC_BIT_TOGGLE-1:0] == $past(page_rx_word[PNPC_BIT_TOGGLE-1:0]);
  endproperty
  a_code_field: assert property (p_code_field) else $error("code field not loaded");

  property p_page_ro;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_write && reg_addr == PNPC_ADDR_PARTNER_PAGE && !page_rx_strobe) |=> $stable(page_reg);
  endproperty
  a_page_ro: assert property (p_page_ro) else $error("page word changed by write");

  property p_flag_set;
    @(posedge clock) disable iff (!rst_sync_reg)
    page_rx_strobe |=> page_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("page flag not set");

  property p_flag_clear;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_read && reg_addr == PNPC_ADDR_PAGE_STATUS && !page_rx_strobe) |=> !page_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("page flag not cleared by read");

  property p_status_read;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_read && reg_addr == PNPC_ADDR_PAGE_STATUS) |=> reg_rdata == {15'h0000, $past(page_flag_reg)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  property p_received_copy;
    @(posedge clock) disable iff (!rst_sync_reg)
    ##1 page_received == $past(page_flag_reg);
  endproperty
  a_received_copy: assert property (p_received_copy) else $error("page received output wrong");

  property p_fiber_hold;
    @(posedge clock) disable iff (!rst_sync_reg)
    (strap_taken_reg && !(reg_write && reg_addr == PNPC_ADDR_PORT_CONFIG))
      |=> $stable(config_reg[PNPC_BIT_FIBER]);
  endproperty
  a_fiber_hold: assert property (p_fiber_hold) else $error("fiber bit changed after strap");

  property p_strap_once;
    @(posedge clock) disable iff (!rst_sync_reg)
    strap_taken_reg |=> strap_taken_reg;
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("strap capture repeated");

  property p_strap_settle;
    @(posedge clock) disable iff (!rst_sync_reg)
    (strap_wait_reg == PNPC_STRAP_SETTLE && !strap_taken_reg) |=> strap_taken_reg;
  endproperty
  a_strap_settle: assert property (p_strap_settle) else $error("strap never captured");

  property p_rdata_idle;
    @(posedge clock) disable iff (!rst_sync_reg)
    !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");

  property p_config_read;
    @(posedge clock) disable iff (!rst_sync_reg)
    (reg_read && reg_addr == PNPC_ADDR_PORT_CONFIG) |=> reg_rdata == $past(config_reg);
  endproperty
  a_config_read: assert property (p_config_read) else $error("config read data wrong");
endmodule : pnpc_regs
`default_nettype wire

/* File: tb/pnpc_regs_tb.sv */
// self-checking bench for the partner page and port configuration registers
`timescale 1ns/1ps
`default_nettype none
module pnpc_regs_tb;
  import pnpc_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic media_select_pin = 1'b1;
  logic page_rx_strobe = 1'b0;
  logic [15:0] page_rx_word = 16'h0000;
  pnpc_ctrl_t ctrl;
  logic page_received;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  pnpc_regs u_pnpc_regs (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .media_select_pin(media_select_pin),
    .page_rx_strobe(page_rx_strobe), .page_rx_word(page_rx_word), .ctrl(ctrl), .page_received(page_received));

  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  // read data stands only in the cycle after the strobe, so it is taken just past that edge
  task automatic rd_check(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check_val(reg_rdata, exp, what);
  endtask : rd_check

  // ctrl carries config bits 14:7, 5 and 3:0 in that order
  function automatic logic [15:0] ctrl_of(input logic [15:0] w);
    return {3'h0, w[14:7], w[5], w[3:0]};
  endfunction : ctrl_of

  task automatic do_reset(input logic strap);
    @(posedge clock);
    nrst <= 1'b0;
    media_select_pin <= strap;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (10) @(posedge clock);
  endtask : do_reset

  task automatic test_reset(input logic strap);
    do_reset(strap);
    rd_check(PNPC_ADDR_PORT_CONFIG, {15'h0042, strap}, "config reset");
    check_val(16'({3'h0, ctrl}), ctrl_of({15'h0042, strap}), "ctrl reset");
    rd_check(PNPC_ADDR_PARTNER_PAGE, 16'h0000, "page reset");
    check_val(16'(page_received), 16'h0000, "flag reset");
  endtask : test_reset

  // walk a single one through every writable config bit; reserved bits are written as zero and must read zero
  task automatic test_config();
    logic [15:0] w;
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      reg_wr(PNPC_ADDR_PORT_CONFIG, w & PNPC_CONFIG_WMASK);
      rd_check(PNPC_ADDR_PORT_CONFIG, w & 16'h7faf, "config bit");
      check_val(16'({3'h0, ctrl}), ctrl_of(w), "ctrl bit");
    end
    reg_wr(PNPC_ADDR_PORT_CONFIG, 16'hffff & PNPC_CONFIG_WMASK);
    rd_check(PNPC_ADDR_PORT_CONFIG, 16'h7faf, "config ones");
    check_val(16'({3'h0, ctrl}), 16'h1fff, "ctrl ones");
  endtask : test_config

  task automatic send_page(input logic [15:0] w);
    @(posedge clock);
    page_rx_word <= w;
    page_rx_strobe <= 1'b1;
    @(posedge clock);
    page_rx_strobe <= 1'b0;
    page_rx_word <= ~w;
  endtask : send_page

  task automatic test_page();
    send_page(16'hd5a3);
    rd_check(PNPC_ADDR_PARTNER_PAGE, 16'hd5a3, "page word");
    rd_check(PNPC_ADDR_PARTNER_PAGE, 16'hd5a3, "page reread");
    check_val(16'(page_received), 16'h0001, "page flag");
    reg_wr(PNPC_ADDR_PARTNER_PAGE, 16'h0000);
    rd_check(PNPC_ADDR_PARTNER_PAGE, 16'hd5a3, "page write ignored");
    rd_check(PNPC_ADDR_PAGE_STATUS, 16'h0001, "status set");
    rd_check(PNPC_ADDR_PAGE_STATUS, 16'h0000, "status cleared");
    check_val(16'(page_received), 16'h0000, "page flag cleared");
    send_page(16'h2a5c);
    rd_check(PNPC_ADDR_PARTNER_PAGE, 16'h2a5c, "page inverse");
    rd_check(5'h1f, 16'h0000, "unmapped");
  endtask : test_page

  // a hang ends the run as a failure
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    test_reset(1'b1);
    test_config();
    test_page();
    test_reset(1'b0);
    stop_test();
  end
endmodule : pnpc_regs_tb
`default_nettype wire
